// File: rtl/dcw_pkg.sv
// shared constants for the drive command word decoder
package dcw_pkg;
  // register byte offsets on apb
  localparam logic [7:0]  CMD_WORD_OFS   = 8'h00;  // drive_command_word
  localparam logic [7:0]  CONFIG_OFS     = 8'h04;  // channel and mode setup
  localparam logic [7:0]  STATUS_OFS     = 8'h08;  // decoded command levels
  localparam logic [7:0]  FITTED_OFS     = 8'h0c;  // module presence, read only
  // reset values
  localparam logic [15:0] CMD_WORD_RST   = 16'h0000;
  localparam logic [2:0]  CHAN_RST       = 3'h0;   // terminal block
  localparam logic [1:0]  MODE_RST       = 2'h0;   // drive profile
  // config field positions
  localparam int CFG_CMD_CHAN_LSB  = 0;
  localparam int CFG_REF_CHAN_LSB  = 4;
  localparam int CFG_MODE_LSB      = 8;
  localparam int CFG_OWN_CHAN_LSB  = 12;
  // channel encodings, shared by command and reference selection
  localparam logic [2:0] CH_TERMINAL = 3'h0;
  localparam logic [2:0] CH_DISPLAY  = 3'h1;  // display_terminal_source
  localparam logic [2:0] CH_MODBUS   = 3'h2;
  localparam logic [2:0] CH_CANOPEN  = 3'h3;
  localparam logic [2:0] CH_FIELDBUS = 3'h4;
  localparam logic [2:0] CH_ETHERNET = 3'h5;
  // control modes
  localparam logic [1:0] MODE_DRIVE   = 2'h0;
  localparam logic [1:0] MODE_IO_LVL  = 2'h1;
  localparam logic [1:0] MODE_IO_EDGE = 2'h2;
  // command word bit positions
  localparam int B_SWITCH_ON = 0;
  localparam int B_VOLTAGE   = 1;
  localparam int B_QSTOP_N   = 2;
  localparam int B_ENABLE_OP = 3;
  localparam int B_FAULT_RST = 7;
  localparam int B_HALT      = 8;
  localparam int B_RUN_AUTH  = 0;
  localparam int B_FWD_EDGE  = 1;
  localparam int B_FWD_LVL   = 0;
  localparam int B_ASSIGN_LSB = 11;
endpackage

// File: rtl/dcw_rise_det.sv
// rising edge detector for one command bit
`timescale 1ns/1ps
module dcw_rise_det (
  input  wire logic pclk,     // system clock
  input  wire logic presetn,  // async reset, low
  input  wire logic ce,       // clock enable
  input  wire logic clr,      // suppress pulse, history still tracks level
  input  wire logic level,    // sampled bit
  output logic      pulse     // one-cycle rise pulse
);
  logic prev_q;  // bit value last cycle
  logic rise;    // combinational rise

  // rise seen when previous zero and now one
  assign rise = level & ~prev_q & ~clr;

  // history and registered pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      pulse  <= 1'b0;
    end else if (ce) begin
      prev_q <= level;
      pulse  <= rise;
    end
  end
endmodule

// File: rtl/dcw_decoder.sv
// drive command word decoder with apb register access
`timescale 1ns/1ps
// What this block does
// - command source from configured, fitted channel
// - reference channel uses same encodings
// - drive profile unless io profile selected
// - bit 0 one gives contactor command
// - bit 1 zero disables voltage
// - bit 2 zero requests quick stop
// - bit 3 one enables operation, run
// - fault reset on bit 7 rise only
// - bit 8 halt stop, stay enabled
// - level io: bit 0 forward command
// - level bit 0 only on active channel
// - edge io: bit 0 run authorization
// - edge io: forward on bit 1 rise
// - edge io bits 0,1 not reassignable
module dcw_decoder (
  input  wire logic        pclk,          // system clock
  input  wire logic        presetn,       // async reset, low
  input  wire logic        ce,            // clock enable, freezes state
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  input  wire logic        canopen_fit,   // canopen module present, pin
  input  wire logic        fieldbus_fit,  // fieldbus module present, pin
  input  wire logic        ethernet_fit,  // embedded ethernet present, pin
  output logic             switch_on,     // contactor command
  output logic             disable_volt,  // withdraw supply authorization
  output logic             quick_stop,    // quick stop request
  output logic             run_cmd,       // run or forward command
  output logic             fault_reset,   // one-cycle fault reset pulse
  output logic             halt_stop,     // halt with halt_stop_style
  output logic             fwd_pulse,     // one-cycle edge forward
  output logic             run_auth,      // edge mode run authorization
  output logic             io_stop,       // edge mode forced stop
  output logic [4:0]       assign_bits,   // freely assignable command bits
  output logic [2:0]       cmd_chan,      // active command channel
  output logic [2:0]       ref_chan       // active reference channel
);
  // registers
  logic [15:0] cmd_word_q;   // drive_command_word
  logic [2:0]  cmd_sel_q;    // requested command channel
  logic [2:0]  ref_sel_q;    // requested reference channel
  logic [1:0]  mode_q;       // control mode
  logic [2:0]  own_chan_q;   // channel owning the word
  logic [2:0]  fit_s1_q;     // presence sync stage one
  logic [2:0]  fit_q;        // presence synced
  logic [31:0] prdata_d;     // next read data
  logic        slverr_d;     // next error

  // apb decode
  wire access   = psel & penable & ce;
  wire wr       = access & pwrite;
  wire hit_cmd  = paddr == dcw_pkg::CMD_WORD_OFS;
  wire hit_cfg  = paddr == dcw_pkg::CONFIG_OFS;
  wire hit_sts  = paddr == dcw_pkg::STATUS_OFS;
  wire hit_fit  = paddr == dcw_pkg::FITTED_OFS;
  wire hit_any  = hit_cmd | hit_cfg | hit_sts | hit_fit;
  wire wr_cmd   = wr & hit_cmd;
  wire wr_cfg   = wr & hit_cfg;

  // presence synchroniser, first stage read only by second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fit_s1_q <= 3'h0;
      fit_q    <= 3'h0;
    end else if (ce) begin
      fit_s1_q <= {ethernet_fit, fieldbus_fit, canopen_fit};
      fit_q    <= fit_s1_q;
    end
  end

  function automatic logic [2:0] chan_ok(input logic [2:0] ch, input logic [2:0] fit);
    logic [2:0] r;
    r = dcw_pkg::CH_TERMINAL;
    unique case (ch)
      dcw_pkg::CH_TERMINAL, dcw_pkg::CH_DISPLAY, dcw_pkg::CH_MODBUS: r = ch;
      dcw_pkg::CH_CANOPEN:  r = fit[0] ? ch : dcw_pkg::CH_TERMINAL;
      dcw_pkg::CH_FIELDBUS: r = fit[1] ? ch : dcw_pkg::CH_TERMINAL;
      dcw_pkg::CH_ETHERNET: r = fit[2] ? ch : dcw_pkg::CH_TERMINAL;
      default:              r = dcw_pkg::CH_TERMINAL;  // unused codes
    endcase
    return r;
  endfunction

  wire [2:0] cmd_chan_d = chan_ok(cmd_sel_q, fit_q);
  wire [2:0] ref_chan_d = chan_ok(ref_sel_q, fit_q);

  // mode decode
  // anything not io is drive profile
  wire io_lvl   = mode_q == dcw_pkg::MODE_IO_LVL;
  wire io_edge  = mode_q == dcw_pkg::MODE_IO_EDGE;
  wire drv_mode = ~io_lvl & ~io_edge;
  wire owns     = own_chan_q == cmd_chan_d;

  // register writes; reserved bits stored as written
  // reserved bits left to controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_word_q <= dcw_pkg::CMD_WORD_RST;
    end else if (wr_cmd) begin
      cmd_word_q <= pwdata[15:0];
    end
  end

  // configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_sel_q  <= dcw_pkg::CHAN_RST;
      ref_sel_q  <= dcw_pkg::CHAN_RST;
      mode_q     <= dcw_pkg::MODE_RST;
      own_chan_q <= dcw_pkg::CHAN_RST;
    end else if (wr_cfg) begin
      cmd_sel_q  <= pwdata[dcw_pkg::CFG_CMD_CHAN_LSB +: 3];
      ref_sel_q  <= pwdata[dcw_pkg::CFG_REF_CHAN_LSB +: 3];
      mode_q     <= pwdata[dcw_pkg::CFG_MODE_LSB +: 2];
      own_chan_q <= pwdata[dcw_pkg::CFG_OWN_CHAN_LSB +: 3];
    end
  end

  // edge detectors, pulses suppressed outside their mode
  logic fr_pulse;  // fault reset rise
  logic fw_pulse;  // forward rise

  // fault reset on bit 7 rise
  dcw_rise_det u_fault_rise (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clr     (~drv_mode),
    .level   (cmd_word_q[dcw_pkg::B_FAULT_RST]),
    .pulse   (fr_pulse)
  );

  dcw_rise_det u_fwd_rise (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clr     (~io_edge | ~cmd_word_q[dcw_pkg::B_RUN_AUTH]),
    .level   (cmd_word_q[dcw_pkg::B_FWD_EDGE]),
    .pulse   (fw_pulse)
  );

  // decoded command levels
  // contactor from bit 0
  wire sw_on_d  = drv_mode & cmd_word_q[dcw_pkg::B_SWITCH_ON];
  wire dis_v_d  = drv_mode & ~cmd_word_q[dcw_pkg::B_VOLTAGE];
  wire qstop_d  = drv_mode & ~cmd_word_q[dcw_pkg::B_QSTOP_N];
  wire halt_d   = drv_mode & cmd_word_q[dcw_pkg::B_HALT];
  wire auth_d   = io_edge & cmd_word_q[dcw_pkg::B_RUN_AUTH];
  wire istop_d  = io_edge & ~cmd_word_q[dcw_pkg::B_RUN_AUTH];
  wire fwd_lvl  = io_lvl & owns & cmd_word_q[dcw_pkg::B_FWD_LVL];
  wire run_d    = (drv_mode & cmd_word_q[dcw_pkg::B_ENABLE_OP]) | fwd_lvl;
  // edge bits 0,1 fixed; only 11..15 assignable
  wire [4:0] asg_d = cmd_word_q[15:dcw_pkg::B_ASSIGN_LSB];

  // registered command outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_on    <= 1'b0;
      disable_volt <= 1'b0;
      quick_stop   <= 1'b0;
      run_cmd      <= 1'b0;
      halt_stop    <= 1'b0;
      run_auth     <= 1'b0;
      io_stop      <= 1'b0;
      assign_bits  <= 5'h00;
      cmd_chan     <= dcw_pkg::CHAN_RST;
      ref_chan     <= dcw_pkg::CHAN_RST;
    end else if (ce) begin
      switch_on    <= sw_on_d;
      disable_volt <= dis_v_d;
      quick_stop   <= qstop_d;
      run_cmd      <= run_d;
      halt_stop    <= halt_d;
      run_auth     <= auth_d;
      io_stop      <= istop_d;
      assign_bits  <= asg_d;
      cmd_chan     <= cmd_chan_d;
      ref_chan     <= ref_chan_d;
    end
  end

  // pulse outputs straight from detector flops
  assign fault_reset = fr_pulse;
  assign fwd_pulse   = fw_pulse;

  // read mux
  always_comb begin
    prdata_d = 32'h0000_0000;
    slverr_d = 1'b0;
    if (hit_cmd) begin
      prdata_d[15:0] = cmd_word_q;
    end else if (hit_cfg) begin
      prdata_d[dcw_pkg::CFG_CMD_CHAN_LSB +: 3] = cmd_sel_q;
      prdata_d[dcw_pkg::CFG_REF_CHAN_LSB +: 3] = ref_sel_q;
      prdata_d[dcw_pkg::CFG_MODE_LSB +: 2]     = mode_q;
      prdata_d[dcw_pkg::CFG_OWN_CHAN_LSB +: 3] = own_chan_q;
    end else if (hit_sts) begin
      prdata_d[10:0] = {run_auth, io_stop, halt_stop, run_cmd, quick_stop,
                        disable_volt, switch_on, 1'b0, cmd_chan};
      prdata_d[18:16] = ref_chan;
    end else if (hit_fit) begin
      prdata_d[2:0] = fit_q;
    end else begin
      slverr_d = ~hit_any;  // unmapped address
    end
  end

  // apb answer: zero wait, registered from setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else if (ce) begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & slverr_d;
      prdata  <= (psel & ~penable & ~pwrite) ? prdata_d : 32'h0000_0000;
    end
  end

endmodule

// File: bench/dcw_chk.sv
// port checks for the drive command word decoder
`timescale 1ns/1ps
module dcw_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        switch_on,
  input wire logic        disable_volt,
  input wire logic        quick_stop,
  input wire logic        halt_stop,
  input wire logic        fault_reset,
  input wire logic        fwd_pulse,
  input wire logic        run_auth,
  input wire logic [4:0]  assign_bits,
  input wire logic [2:0]  cmd_chan
);
  logic [1:0] mode_q;  // mode seen on config writes
  wire acc = psel && penable && pready && pwrite && ce;
  wire wr0 = acc && paddr == 8'h00;
  wire drv = mode_q != 2'h1 && mode_q != 2'h2;
  // follow config writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_q <= 2'h0;
    else if (acc && paddr == 8'h04) mode_q <= pwdata[9:8];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_assign_copy: assert property (
    wr0 ##1 ce |=> assign_bits == $past(pwdata[15:11], 2)) else $error("assign bits wrong");
  a_switch_bit: assert property (
    wr0 && drv ##1 ce |=> switch_on == $past(pwdata[0], 2)) else $error("switch on wrong");
  a_volt_bit: assert property (
    wr0 && drv ##1 ce |=> disable_volt != $past(pwdata[1], 2)) else $error("voltage wrong");
  a_qstop_bit: assert property (
    wr0 && drv ##1 ce |=> quick_stop != $past(pwdata[2], 2)) else $error("quick stop wrong");
  a_halt_bit: assert property (
    wr0 && drv ##1 ce |=> halt_stop == $past(pwdata[8], 2)) else $error("halt wrong");
  a_fault_once: assert property (
    fault_reset |=> !fault_reset) else $error("fault pulse long");
  a_fwd_auth: assert property (
    fwd_pulse |-> run_auth ##1 !fwd_pulse) else $error("forward pulse bad");
  a_chan_legal: assert property (
    cmd_chan <= 3'h5) else $error("channel code bad");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  c_fault: cover property (fault_reset);
  c_fwd: cover property (fwd_pulse);
  c_err: cover property (pslverr);
endmodule
bind dcw_decoder dcw_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .switch_on(switch_on), .disable_volt(disable_volt),
  .quick_stop(quick_stop), .halt_stop(halt_stop), .fault_reset(fault_reset),
  .fwd_pulse(fwd_pulse), .run_auth(run_auth), .assign_bits(assign_bits), .cmd_chan(cmd_chan));

// File: bench/dcw_apb_src.sv
// apb command source standing in for the network master
`timescale 1ns/1ps
module dcw_apb_src (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic hung = 1'b0;  // set when a wait ran out
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one full transfer, bounded wait on pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= (a == 8'h00) ? (d & 32'h0000f98f) : d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 50);
    hung = !pready;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule

// File: bench/test_drive_command_word_decoder.sv
// self-checking bench for the command word decoder
`timescale 1ns/1ps
module test_drive_command_word_decoder;
  typedef struct packed {logic [15:0] cfg; logic [15:0] word; logic [6:0] mask, exp;} dcw_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, err;
  logic        ce = 1'b1;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        switch_on, disable_volt, quick_stop, run_cmd, fault_reset, halt_stop;
  logic        fwd_pulse, run_auth, io_stop;
  logic [4:0]  assign_bits;
  logic [2:0]  cmd_chan, ref_chan;
  int          n_mismatch = 0, checks = 0;
  wire  [6:0]  lv = {switch_on, disable_volt, quick_stop, run_cmd, halt_stop, run_auth, io_stop};
  dcw_row_t rows[8] = '{'{16'h0000, 16'h0001, 7'h7c, 7'h70}, '{16'h0000, 16'h010e, 7'h7c, 7'h0c},
    '{16'h0300, 16'h0008, 7'h7c, 7'h38}, '{16'h0100, 16'h0001, 7'h08, 7'h08},
    '{16'h2100, 16'h0001, 7'h08, 7'h00}, '{16'h2102, 16'h0001, 7'h08, 7'h08},
    '{16'h0200, 16'h0000, 7'h03, 7'h01}, '{16'h0200, 16'h0001, 7'h03, 7'h02}};
  always #5 pclk = ~pclk;
  dcw_apb_src src (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dcw_decoder dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .canopen_fit(1'b0), .fieldbus_fit(1'b1), .ethernet_fit(1'b1),
    .switch_on(switch_on), .disable_volt(disable_volt), .quick_stop(quick_stop),
    .run_cmd(run_cmd), .fault_reset(fault_reset), .halt_stop(halt_stop), .fwd_pulse(fwd_pulse),
    .run_auth(run_auth), .io_stop(io_stop), .assign_bits(assign_bits), .cmd_chan(cmd_chan),
    .ref_chan(ref_chan));
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bus access, a hang ends the run
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    src.xfer(w, a, d, rd, err);
    if (src.hung) begin
      n_mismatch++;
      close_out();
    end
  endtask
  task automatic settle;
    @(posedge pclk);
    #1;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b0 | 1'b1;
    #1;
    chk({25'h0, lv}, 32'h0);
    acc(1'b0, dcw_pkg::CMD_WORD_OFS, 32'h0);
    chk(rd, {16'h0, dcw_pkg::CMD_WORD_RST});
    $display("reset test done");
    foreach (rows[i]) begin
      acc(1'b1, dcw_pkg::CONFIG_OFS, {16'h0, rows[i].cfg});
      acc(1'b1, dcw_pkg::CMD_WORD_OFS, {16'h0, rows[i].word});
      settle();
      chk({25'h0, lv & rows[i].mask}, {25'h0, rows[i].exp});
    end
    $display("row table done");
    for (int c = 0; c < 8; c++) begin
      logic [2:0] e;
      e = (c > 5 || c == 3) ? 3'h0 : c[2:0];
      acc(1'b1, dcw_pkg::CONFIG_OFS, {25'h0, c[2:0], 1'b0, c[2:0]});
      settle();
      chk({26'h0, cmd_chan, ref_chan}, {26'h0, e, e});
    end
    $display("channel test done");
    acc(1'b1, dcw_pkg::CMD_WORD_OFS, 32'h80);
    settle();
    chk(fault_reset, 32'h1);
    settle();
    chk(fault_reset, 32'h0);
    acc(1'b1, dcw_pkg::CMD_WORD_OFS, 32'h80);
    settle();
    chk(fault_reset, 32'h0);
    acc(1'b1, dcw_pkg::CMD_WORD_OFS, 32'h1);
    ce <= 1'b0;
    settle();
    chk(switch_on, 32'h0);
    ce <= 1'b1;
    settle();
    chk(switch_on, 32'h1);
    acc(1'b0, dcw_pkg::FITTED_OFS, 32'h0);
    chk(rd, 32'h6);
    $display("fault reset test done");
    acc(1'b1, dcw_pkg::CONFIG_OFS, 32'h200);
    acc(1'b1, dcw_pkg::CMD_WORD_OFS, 32'h2);
    settle();
    chk(fwd_pulse, 32'h0);
    acc(1'b1, dcw_pkg::CMD_WORD_OFS, 32'h1);
    acc(1'b1, dcw_pkg::CMD_WORD_OFS, 32'h3);
    settle();
    chk(fwd_pulse, 32'h1);
    acc(1'b1, dcw_pkg::CMD_WORD_OFS, 32'hf803);
    acc(1'b0, dcw_pkg::CMD_WORD_OFS, 32'h0);
    chk(rd, 32'hf803);
    chk(assign_bits, 32'h1f);
    acc(1'b0, 8'h10, 32'h0);
    chk(err, 32'h1);
    $display("edge and bus test done");
    close_out();
  end
endmodule
